// ### logic/iev_pkg.sv
package iev_pkg;

	// Register addresses on the plain register port
	localparam logic [7:0] IEV_ADDR_EN_MAIN = 8'hA8;
	localparam logic [7:0] IEV_ADDR_EN_EXT = 8'hB0;
	localparam logic [7:0] IEV_ADDR_EN_PERI = 8'hC0;
	localparam logic [7:0] IEV_ADDR_STATUS = 8'hC8;
	localparam logic [7:0] IEV_ADDR_MASK = 8'hD0;

	// Reset values
	localparam logic [7:0] IEV_EN_RESET = 8'h00;
	localparam logic [7:0] IEV_STAT_RESET = 8'h00;
	localparam logic [7:0] IEV_RDATA_IDLE = 8'h00;

	// Implemented bits of each enable register, reserved bits clear
	localparam logic [7:0] IEV_IMPL_MAIN = 8'hBF;
	localparam logic [7:0] IEV_IMPL_EXT = 8'h1F;
	localparam logic [7:0] IEV_IMPL_PERI = 8'h7F;

	// Global enable position in the main enable register
	localparam int IEV_GLOBAL_BIT = 7;

	// Status and mask layout
	localparam int IEV_ST_TAKEN = 0;
	localparam int IEV_ST_BLOCKED = 1;
	localparam int IEV_ST_RSVD_WR = 2;
	localparam logic [7:0] IEV_ST_IMPL = 8'h07;

	// Sources, numbered in vector order
	localparam int IEV_NSRC = 18;
	localparam int IEV_SRC_EXT6 = 15;

	// Vector address: base plus index times eight
	localparam logic [15:0] IEV_VEC_BASE = 16'h0003;
	localparam int IEV_VEC_SHIFT = 3;

	// Which enable register holds each source's bit
	typedef enum logic [1:0] {
		IEV_R_MAIN,
		IEV_R_EXT,
		IEV_R_PERI
	} iev_reg_e;

	localparam iev_reg_e IEV_EN_REG [IEV_NSRC] = '{
		IEV_R_MAIN, IEV_R_MAIN, IEV_R_MAIN, IEV_R_MAIN, IEV_R_MAIN,
		IEV_R_MAIN, IEV_R_PERI, IEV_R_PERI, IEV_R_PERI, IEV_R_EXT,
		IEV_R_EXT, IEV_R_EXT, IEV_R_PERI, IEV_R_PERI, IEV_R_EXT,
		IEV_R_EXT, IEV_R_PERI, IEV_R_PERI};

	localparam logic [2:0] IEV_EN_BIT [IEV_NSRC] = '{
		3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h4, 3'h6,
		3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h0, 3'h1};

	// Request lines, packed so that bit n is source n
	typedef struct packed {
		logic timer45_request;
		logic timer3_request;
		logic ext_pin6_unused;
		logic ext_pin5_request;
		logic serial_unit2_request;
		logic serial_unit1_request;
		logic ext_pin4_request;
		logic ext_pin3_request;
		logic ext_pin2_request;
		logic converter_done_request;
		logic freq_counter_request;
		logic watchdog_request;
		logic timer2_request;
		logic serial_port_request;
		logic timer1_request;
		logic ext_pin1_request;
		logic timer0_request;
		logic ext_pin0_request;
	} iev_req_s;

	// Register port from software
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} iev_bus_s;

	// Vector offered to the core
	typedef struct packed {
		logic valid;
		logic [4:0] src;
		logic [15:0] addr;
	} iev_vec_s;

	typedef enum {
		IEV_IDLE,
		IEV_OFFER
	} iev_state_e;

endpackage

// ### logic/iev_fall_edge.sv
`timescale 1ns/10ps
module iev_fall_edge (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pin,
	input wire logic clear,
	output logic pending
);

	// Previous pin level; idles high so reset makes no edge
	logic pin_reg;
	// Latched edge request
	logic pend_reg;

	// Pin history
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_reg <= 1'b1;
		end else begin
			pin_reg <= pin;
		end
	end

	// Only a high-to-low step sets; rising edges and low levels ignored
	// A new edge in the clear cycle wins, so no event is lost
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pend_reg <= 1'b0;
		end else if (pin_reg && !pin) begin
			pend_reg <= 1'b1;
		end else if (clear) begin
			pend_reg <= 1'b0;
		end
	end

	assign pending = pend_reg;

endmodule

// ### logic/iev_top.sv
`timescale 1ns/10ps
// Contract
// - Enable bit 0 blocks, 1 allows source
// - Taken only with global and own enable
// - Main bits 1,3,4,5: timers, serial, timer2
// - Pins 0,1 main; pins 2-6 second register
// - Main bit 6, second bits 7:5 reserved
// - Vectors from 0003H, 8-byte steps to 0043H
// - Vectors 004BH onward, timers 4/5 share 008BH
// - Third register: timer3,timer4,serial1,serial2,counter,watchdog,converter
module iev_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input iev_pkg::iev_bus_s bus,
	input iev_pkg::iev_req_s req,
	input wire logic ext_pin6_in,
	input wire logic [iev_pkg::IEV_NSRC-1:0] prio_high,
	input wire logic vec_ack,
	output logic [7:0] rdata,
	output iev_pkg::iev_vec_s vec,
	output logic irq
);
	import iev_pkg::*;

	// Enable registers, reserved bits never stored
	logic [7:0] en_main_reg;
	logic [7:0] en_ext_reg;
	logic [7:0] en_peri_reg;

	// Sticky event status and its mask
	// Both hold only the three implemented event bits
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] mask_reg;

	// Read data, valid the cycle after the strobe
	// Zero outside that cycle so a stray sample reads nothing
	logic [7:0] rdata_reg;

	// Interrupt output flop
	// Registered so the core never sees a combinational glitch
	logic irq_reg;

	// Vector handshake state
	// Two states suffice: the core takes one offer at a time
	iev_state_e state_reg;
	iev_vec_s vec_reg;

	// Per-source terms
	// Index n is always source n in vector order
	logic [IEV_NSRC-1:0] req_vec;
	logic [IEV_NSRC-1:0] src_en;
	logic [IEV_NSRC-1:0] pending;
	logic [IEV_NSRC-1:0] hi_pending;
	logic [IEV_NSRC-1:0] choose_from;
	logic global_en;
	logic any_req;

	// Winner of the selection
	// Index fits five bits; eighteen sources in all
	logic [4:0] win_idx;
	logic win_valid;

	// Falling-edge latch for pin 6
	// The latch clears only when its vector is accepted
	logic ext6_pending;
	logic ext6_clear;

	// Event pulses
	// Taken and reserved-write last one cycle, blocked as long as its cause; the status register keeps them
	logic ev_taken;
	logic ev_blocked;
	logic ev_rsvd_wr;

	// Decoded writes
	// Read and write strobes never come together
	logic wr_main;
	logic wr_ext;
	logic wr_peri;
	logic wr_status;
	logic wr_mask;

	assign wr_main = bus.wr && (bus.addr == IEV_ADDR_EN_MAIN);
	assign wr_ext = bus.wr && (bus.addr == IEV_ADDR_EN_EXT);
	assign wr_peri = bus.wr && (bus.addr == IEV_ADDR_EN_PERI);
	assign wr_status = bus.wr && (bus.addr == IEV_ADDR_STATUS);
	assign wr_mask = bus.wr && (bus.addr == IEV_ADDR_MASK);

	// Pin 6 has no level mode; the edge latch is its only request
	iev_fall_edge u_ext6 (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pin(ext_pin6_in),
		.clear(ext6_clear),
		.pending(ext6_pending)
	);

	// Request vector in vector order; slot 15 comes from the edge latch
	// The raw field for slot 15 is ignored: pin 6 has no level mode
	always_comb begin
		req_vec = req;
		req_vec[IEV_SRC_EXT6] = ext6_pending;
	end

	// Global enable sits at the top of the main register
	// It gates every source, whatever its own bit says
	assign global_en = en_main_reg[IEV_GLOBAL_BIT];

	// Route each source to its own enable bit
	// Package tables pick register and bit, so no muxing at run time
	genvar gi;
	generate
		for (gi = 0; gi < IEV_NSRC; gi++) begin : g_src
			if (IEV_EN_REG[gi] == IEV_R_MAIN) begin : g_main
				// Pins 0,1, timers 0-2, serial port
				assign src_en[gi] = en_main_reg[IEV_EN_BIT[gi]];
			end else if (IEV_EN_REG[gi] == IEV_R_EXT) begin : g_ext
				// Pins 2 to 6
				assign src_en[gi] = en_ext_reg[IEV_EN_BIT[gi]];
			end else begin : g_peri
				// Timers 3/4, serial units, counter, watchdog, converter
				assign src_en[gi] = en_peri_reg[IEV_EN_BIT[gi]];
			end
			// A zero enable blocks, a one lets the request through
			assign pending[gi] = req_vec[gi] && src_en[gi]
				&& global_en;
		end
	endgenerate

	// Any enabled request while global enable is off counts as blocked
	// Lets software notice that it forgot the global bit
	assign any_req = |(req_vec & src_en);

	// High-priority group first; within a group lowest index wins
	assign hi_pending = pending & prio_high;
	assign choose_from = (|hi_pending) ? hi_pending : pending;

	// Lowest set bit gives the lowest vector address
	// Scan from the top so the last hit is the lowest index
	always_comb begin
		win_idx = 5'h00;
		win_valid = 1'b0;
		for (int i = IEV_NSRC - 1; i >= 0; i--) begin
			if (choose_from[i]) begin
				win_idx = 5'(i);
				win_valid = 1'b1;
			end
		end
	end

	// Vector address: base plus eight bytes per slot
	// Slot 17 lands on the entry shared by timers 4 and 5
	function automatic logic [15:0] vec_addr(input logic [4:0] idx);
		vec_addr = IEV_VEC_BASE + (16'(idx) << IEV_VEC_SHIFT);
	endfunction

	// Clear the pin 6 latch when its vector is accepted
	assign ext6_clear = (state_reg == IEV_OFFER) && vec_ack
		&& (vec_reg.src == 5'(IEV_SRC_EXT6));

	// Offer handshake: hold vector until the core acknowledges
	// Choice is frozen once offered, so a later request waits its turn
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= IEV_IDLE;
		end else begin
			unique case (state_reg)
				IEV_IDLE: begin
					// Start an offer as soon as a winner exists
					if (win_valid) begin
						state_reg <= IEV_OFFER;
					end
				end
				IEV_OFFER: begin
					// Back to idle on acknowledge
					if (vec_ack) begin
						state_reg <= IEV_IDLE;
					end
				end
			endcase
		end
	end

	// Vector register driven to the core
	// Fields load once per offer and stand until acknowledge
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			vec_reg <= '0;
		end else if (state_reg == IEV_IDLE && win_valid) begin
			vec_reg.valid <= 1'b1;
			vec_reg.src <= win_idx;
			vec_reg.addr <= vec_addr(win_idx);
		end else if (state_reg == IEV_OFFER && vec_ack) begin
			vec_reg.valid <= 1'b0;
		end
	end

	// Event pulses feeding the sticky status
	assign ev_taken = (state_reg == IEV_OFFER) && vec_ack;
	assign ev_blocked = any_req && !global_en;
	// Flag software that sets a reserved enable bit
	assign ev_rsvd_wr = (wr_main && |(bus.wdata & ~IEV_IMPL_MAIN))
		|| (wr_ext && |(bus.wdata & ~IEV_IMPL_EXT))
		|| (wr_peri && |(bus.wdata & ~IEV_IMPL_PERI));

	// Main enable register; reserved bit 6 dropped
	// Writes land at the strobe edge; no read-modify-write here
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			en_main_reg <= IEV_EN_RESET;
		end else if (wr_main) begin
			en_main_reg <= bus.wdata & IEV_IMPL_MAIN;
		end
	end

	// Second enable register; bits 7:5 dropped
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			en_ext_reg <= IEV_EN_RESET;
		end else if (wr_ext) begin
			en_ext_reg <= bus.wdata & IEV_IMPL_EXT;
		end
	end

	// Third enable register; bit 7 dropped
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			en_peri_reg <= IEV_EN_RESET;
		end else if (wr_peri) begin
			en_peri_reg <= bus.wdata & IEV_IMPL_PERI;
		end
	end

	// Sticky status: write one clears, a same-cycle event wins
	always_comb begin
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~bus.wdata;
		end
		status_next[IEV_ST_TAKEN] = status_next[IEV_ST_TAKEN] | ev_taken;
		status_next[IEV_ST_BLOCKED] = status_next[IEV_ST_BLOCKED]
			| ev_blocked;
		status_next[IEV_ST_RSVD_WR] = status_next[IEV_ST_RSVD_WR]
			| ev_rsvd_wr;
	end

	// Status register
	// Unimplemented bits are masked off on every cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= IEV_STAT_RESET;
		end else begin
			status_reg <= status_next & IEV_ST_IMPL;
		end
	end

	// Mask register, same layout as status
	// A masked event still sets its status bit
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mask_reg <= IEV_STAT_RESET;
		end else if (wr_mask) begin
			mask_reg <= bus.wdata & IEV_ST_IMPL;
		end
	end

	// Level interrupt; lags the status by one cycle, kept as a flop
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_reg & mask_reg);
		end
	end

	// Read data for one cycle after the read strobe, zero otherwise
	// Unmapped addresses read zero; reserved bits read zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= IEV_RDATA_IDLE;
		end else if (bus.rd) begin
			unique case (bus.addr)
				IEV_ADDR_EN_MAIN: rdata_reg <= en_main_reg;
				IEV_ADDR_EN_EXT: rdata_reg <= en_ext_reg;
				IEV_ADDR_EN_PERI: rdata_reg <= en_peri_reg;
				IEV_ADDR_STATUS: rdata_reg <= status_reg;
				IEV_ADDR_MASK: rdata_reg <= mask_reg;
				default: rdata_reg <= IEV_RDATA_IDLE;
			endcase
		end else begin
			rdata_reg <= IEV_RDATA_IDLE;
		end
	end

	// Outputs straight from flops
	// No logic between these flops and the pins
	assign rdata = rdata_reg;
	assign vec = vec_reg;
	assign irq = irq_reg;

endmodule

// ### test/iev_asserts.sv
`timescale 1ns/10ps
module iev_asserts
	import iev_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input iev_pkg::iev_bus_s bus,
	input iev_pkg::iev_req_s req,
	input wire logic [iev_pkg::IEV_NSRC-1:0] prio_high,
	input wire logic vec_ack,
	input wire logic [7:0] rdata,
	input iev_pkg::iev_vec_s vec
);
	logic [7:0] en_reg [3]; // Copy of the three enable registers
	logic [IEV_NSRC-1:0] en_src, pend, en_d, pend_d; // Per source views
	logic [7:0] rd_exp; // Read data due next cycle
	logic rd_chk; // Status and mask reads are not predicted

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Track enable writes; history lines up with the offer edge
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			en_reg <= '{default: 8'h00};
			en_d <= '0;
			pend_d <= '0;
		end else begin
			if (bus.wr && bus.addr == IEV_ADDR_EN_MAIN) en_reg[0] <= bus.wdata;
			if (bus.wr && bus.addr == IEV_ADDR_EN_EXT) en_reg[1] <= bus.wdata;
			if (bus.wr && bus.addr == IEV_ADDR_EN_PERI) en_reg[2] <= bus.wdata;
			en_d <= en_src;
			pend_d <= pend;
		end
	end

	// Pin 6 is a latch inside, so it stays out of the pending view
	always_comb begin
		for (int i = 0; i < IEV_NSRC; i++) begin
			en_src[i] = en_reg[IEV_EN_REG[i]][IEV_EN_BIT[i]];
		end
		pend = en_src & req;
		pend[IEV_SRC_EXT6] = 1'b0;
		case (bus.addr)
			IEV_ADDR_EN_MAIN: rd_exp = en_reg[0] & IEV_IMPL_MAIN;
			IEV_ADDR_EN_EXT: rd_exp = en_reg[1] & IEV_IMPL_EXT;
			IEV_ADDR_EN_PERI: rd_exp = en_reg[2] & IEV_IMPL_PERI;
			default: rd_exp = 8'h00;
		endcase
		if (!bus.rd) rd_exp = 8'h00;
		rd_chk = !bus.rd || !(bus.addr inside {IEV_ADDR_STATUS, IEV_ADDR_MASK});
	end

	sequence s_wait;
		vec.valid && !vec_ack;
	endsequence
	sequence s_taken;
		vec.valid && vec_ack;
	endsequence
	sequence s_new;
		$rose(vec.valid);
	endsequence

	read_value_a:
		assert property ($past(rd_chk) |-> rdata == $past(rd_exp))
		else $error("register read data wrong");
	vec_addr_a:
		assert property (vec.valid |-> vec.addr == IEV_VEC_BASE + {8'h00, vec.src, 3'h0})
		else $error("vector address wrong");
	src_range_a:
		assert property (vec.valid |-> vec.src < 5'd18)
		else $error("vector source out of range");
	vec_hold_a:
		assert property (s_wait |=> vec.valid && $stable(vec))
		else $error("offer changed before ack");
	offer_drop_a:
		assert property (s_taken |=> !vec.valid)
		else $error("offer stayed after ack");
	global_gate_a:
		assert property (s_new |-> $past(en_reg[0][7]))
		else $error("offer with global enable off");
	own_enable_a:
		assert property (s_new |-> en_d[vec.src])
		else $error("offer of a disabled source");
	lowest_first_a:
		assert property (s_new ##0 $past(prio_high) == '0 |->
			(pend_d & ((18'h1 << vec.src) - 18'h1)) == '0)
		else $error("lower pending source skipped");
endmodule

bind iev_top iev_asserts u_asserts (.clk_sys(clk_sys), .rst_b(rst_b),
	.bus(bus), .req(req), .prio_high(prio_high), .vec_ack(vec_ack),
	.rdata(rdata), .vec(vec));

// ### test/iev_core_model.sv
`timescale 1ns/10ps
module iev_core_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input iev_pkg::iev_vec_s vec,
	input wire logic [1:0] lag,
	output logic vec_ack
);
	import iev_pkg::*;
	logic [1:0] wait_reg; // Cycles spent looking at the offer

	// Fetch after lag cycles; ack lasts one cycle, the edge it is seen
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wait_reg <= 2'h0;
			vec_ack <= 1'b0;
		end else if (vec.valid && !vec_ack) begin
			vec_ack <= (wait_reg == lag);
			wait_reg <= wait_reg + 2'h1;
		end else begin
			vec_ack <= 1'b0;
			wait_reg <= 2'h0;
		end
	end
endmodule

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
	import iev_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	iev_bus_s bus = '0;
	iev_req_s req = '0;
	logic ext_pin6_in = 1'b1; // Idle high, so reset gives no edge
	logic [IEV_NSRC-1:0] prio_high = '0;
	logic vec_ack, irq;
	logic [7:0] rdata, d;
	iev_vec_s vec;
	logic [1:0] lag = 2'h0;
	logic [7:0] sh [3] = '{default: 8'h00}; // Software copy of enables
	logic [7:0] msk [3] = '{8'hBF, 8'h1F, 8'h7F}; // Implemented bits
	logic [7:0] ra [6] = '{8'hA8, 8'hB0, 8'hC0, 8'hC8, 8'hD0, 8'h55};
	logic p6 = 1'b0; // Pin 6 fall seen, not yet served
	int seed = 6948;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	// Enable position of each source within {third, second, main}
	int en_pos [IEV_NSRC] = '{0, 1, 2, 3, 4, 5, 21, 20, 22, 8, 9, 10, 18,
		19, 11, 12, 16, 17};

	always #4 clk_sys = ~clk_sys;

	iev_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .req(req),
		.ext_pin6_in(ext_pin6_in), .prio_high(prio_high), .vec_ack(vec_ack),
		.rdata(rdata), .vec(vec), .irq(irq));
	iev_core_model u_core (.clk_sys(clk_sys), .rst_b(rst_b), .vec(vec),
		.lag(lag), .vec_ack(vec_ack));

	task stop_test();
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task chk_reg(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task chk_vec(input int e);
		comparisons++;
		if (vec.valid !== 1'b1 || vec_ack !== 1'b1 || vec.src !== 5'(e) ||
			vec.addr !== 16'h0003 + 16'(e * 8)) begin
			num_errors++;
			$display("wrong value at %0t: vector %h want src %0d", $time,
				vec.addr, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		for (int j = 0; j < 3; j++) begin
			if (a == ra[j]) sh[j] = v & msk[j];
		end
	endtask

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		@(negedge clk_sys);
		v = rdata;
	endtask

	// Priority group first, then lowest index; -1 if nothing may go
	function automatic int exp_src();
		logic [23:0] en;
		int best;
		en = {sh[2], sh[1], sh[0]};
		best = -1;
		for (int p = 0; p < 2 && best < 0; p++) begin
			for (int i = IEV_NSRC - 1; i >= 0; i--) begin
				if ((i == 15 ? p6 : req[i]) && en[en_pos[i]] && en[7] &&
					(p == 1 || prio_high[i])) best = i;
			end
		end
		return best;
	endfunction

	// Let the core take every offer, retiring each source once served
	task serve();
		int e;
		int k;
		@(negedge clk_sys);
		e = exp_src();
		while (e >= 0) begin
			for (k = 0; k < 40 && (vec.valid & vec_ack) !== 1'b1; k++)
				@(negedge clk_sys);
			chk_vec(e);
			@(posedge clk_sys);
			if (e != 15) req[e] <= 1'b0;
			@(negedge clk_sys);
			e = exp_src();
		end
		repeat (6) @(negedge clk_sys);
		chk_reg({7'h00, vec.valid}, 8'h00);
	endtask

	// Pin 6 model: any accepted pin 6 vector retires it, even mid-write
	always @(posedge clk_sys) begin
		if (vec.valid && vec_ack && vec.src == 5'd15) p6 = 1'b0;
	end

	// Hang guard, well above the expected run length
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], d);
			chk_reg(d, 8'h00);
		end
		for (int i = 0; i < 30; i++) begin
			for (int j = 0; j < 3; j++) begin
				d = 8'($random(seed));
				if (i % 4 != 0) d = d & msk[j];
				wr(ra[j], d);
				rd(ra[j], d);
				chk_reg(d, sh[j]);
			end
			@(posedge clk_sys);
			d = 8'($random(seed));
			if (ext_pin6_in && !d[0]) p6 = 1'b1;
			ext_pin6_in <= d[0];
			// Let the pin 6 latch set on the same edge as the level requests rise
			@(posedge clk_sys);
			req <= iev_req_s'(18'($random(seed)));
			prio_high <= (i % 3 != 0) ? '0 : 18'($random(seed));
			lag <= d[2:1];
			serve();
			@(posedge clk_sys);
			req <= '0;
		end
		wr(8'hA8, 8'h80);
		wr(8'hB0, 8'h10);
		serve();
		wr(8'hC8, 8'h07);
		wr(8'hD0, 8'h02);
		wr(8'hA8, 8'h01);
		chk_reg({7'h00, irq}, 8'h00);
		@(posedge clk_sys);
		req <= iev_req_s'(18'h00001);
		repeat (3) @(negedge clk_sys);
		chk_reg({6'h00, irq, vec.valid}, 8'h02);
		wr(8'hD0, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk_reg({7'h00, irq}, 8'h00);
		@(posedge clk_sys);
		req <= '0;
		wr(8'hC8, 8'h02);
		rd(8'hC8, d);
		chk_reg(d, 8'h00);
		// A taken vector and a reserved-bit write each leave a status bit
		wr(8'hA8, 8'h81);
		@(posedge clk_sys);
		req <= iev_req_s'(18'h00001);
		serve();
		rd(8'hC8, d);
		chk_reg(d, 8'h01);
		wr(8'hA8, 8'h40);
		rd(8'hC8, d);
		chk_reg(d, 8'h05);
		rd(8'hA8, d);
		chk_reg(d, 8'h00);
		stop_test();
	end
endmodule
